// ===== design/mie_cfg.svh
// constants of the instruction execute block: fields, offsets, resets
// assumes inclusion by bare name from design files and the checker
`ifndef MIE_CFG_SVH
`define MIE_CFG_SVH

// ********************************************************
// instruction word fields
// ********************************************************
`define MIE_IW_W        14
`define MIE_CAT_HI      13
`define MIE_CAT_LO      12
`define MIE_FADDR_HI    6
`define MIE_DEST_BIT    7
`define MIE_BSEL_HI     9
`define MIE_BSEL_LO     7
`define MIE_BOP_HI      11
`define MIE_BOP_LO      10
`define MIE_K8_HI       7
`define MIE_K11_HI      10
`define MIE_GOTO_BIT    11
`define MIE_PORT_A_DATA_REG_ADDR  7'h05
`define MIE_NOP_WORD    14'h0000

// ********************************************************
// timing: four oscillator periods per instruction cycle
// ********************************************************
`define MIE_OSC_PER_CYCLE 4

// ********************************************************
// register offsets and reset values
// ********************************************************
`define MIE_OFS_CTRL    8'h00
`define MIE_OFS_STAT    8'h04
`define MIE_OFS_PC      8'h08
`define MIE_CTRL_RST    1'b0
`define MIE_PC_RST      11'h000
`define MIE_W_RST       8'h00
`define MIE_STAT_C      8
`define MIE_STAT_DC     9
`define MIE_STAT_Z      10
`define MIE_STAT_INJ    11
`define MIE_STAT_RUN    12
`define MIE_RESP_OKAY   2'h0
`define MIE_RESP_SLVERR 2'h2

`endif

// ===== design/mie_pkg.sv
// types of the instruction execute block
// assumes mie_cfg.svh for numeric constants
package mie_pkg;

  // one-hot phase of the instruction cycle
  typedef enum logic [3:0]
  {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } mie_phase_e;

  // decoded operation
  typedef enum logic [3:0]
  {
    OP_NOP      = 4'h0,
    OP_ADDREG   = 4'h1,
    OP_CLRREG   = 4'h2,
    OP_BITCLR   = 4'h3,
    OP_BITSET   = 4'h4,
    OP_SKIPCLR  = 4'h5,
    OP_SKIPSET  = 4'h6,
    OP_ADDLIT   = 4'h7,
    OP_MOVLIT   = 4'h8,
    OP_JUMP     = 4'h9
  } mie_op_e;

endpackage

// ===== design/mie_alu.sv
// 8-bit adder with carry, digit carry and zero outputs
// assumes purely combinational use inside the core
`timescale 1ns/100ps
module mie_alu
(
  // operands
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  // result and flags
  output logic      [7:0] sum,
  output logic            carry,
  output logic            digitCarry,
  output logic            zero
);

  logic [4:0] lowSum;
  logic [8:0] fullSum;

  always_comb
  begin
    lowSum     = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
    fullSum    = {1'b0, opA} + {1'b0, opB};
    sum        = fullSum[7:0];
    carry      = fullSum[8];   // out of bit 7
    digitCarry = lowSum[4];    // out of bit 3
    zero       = (fullSum[7:0] == 8'h00);
  end

endmodule

// ===== design/mie_core.sv
// instruction execute core: fetch, decode, read-modify-write, flags
// assumes program memory and data file answer within one clock on
// the same clock; software reaches control and state over AXI4-Lite
`timescale 1ns/100ps
`include "mie_cfg.svh"

// Operation
// - each instruction is one 14-bit word, opcode plus operand fields
// - destination bit 0 writes working register, 1 writes file register
// - seven-bit file address reaches registers 0x00 to 0x7F
// - bit-select field picks one bit of the addressed 8-bit register
// - literal is 8-bit or 11-bit depending on the category
// - one instruction cycle is four oscillator periods
// - skip taken or program counter change adds a no-op cycle
// - file operand is read, modified, then written back
// - clearing port A still reads it, clearing change condition
// - add literal to working register, update carry, digit, zero
// - add working to file register into chosen destination, flags
// - bit clear zeroes one bit, flags untouched
// - bit set forces one bit high, flags untouched
module mie_core
#(
  parameter int PC_W = 11
)
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // program memory
  output logic [PC_W-1:0]         progAddr,
  input  wire logic [`MIE_IW_W-1:0] progData,
  // data register file
  output logic [6:0]              fileAddr,
  output logic                    fileRdEn,
  input  wire logic [7:0]         fileRdData,
  output logic                    fileWrEn,
  output logic [7:0]              fileWrData,
  output logic                    portARead,
  // axi4-lite write address and data
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  // axi4-lite write response
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // axi4-lite read
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready
);

  // ********************************************************
  // declarations
  // ********************************************************
  mie_pkg::mie_phase_e  phase_r;
  mie_pkg::mie_op_e     op;
  logic [`MIE_IW_W-1:0] ir_r;
  logic [PC_W-1:0]      pc_r;
  logic [7:0]           w_r;
  logic                 c_r;
  logic                 dc_r;
  logic                 z_r;
  logic                 flush_r;
  logic                 flushHold_r;
  logic                 holdPc_r;
  logic                 inject_r;
  logic [7:0]           rd_r;
  logic [7:0]           res_r;
  logic                 resToFile_r;
  logic                 resToW_r;
  logic                 setC_r;
  logic                 setDc_r;
  logic                 setZ_r;
  logic                 newC_r;
  logic                 newDc_r;
  logic                 newZ_r;
  logic                 skip_r;
  logic                 run_r;
  logic [7:0]           bitMask;
  logic [7:0]           addB;
  logic [7:0]           aluSum;
  logic                 aluC;
  logic                 aluDc;
  logic                 aluZ;
  logic                 usesFile;
  logic                 destFile;
  logic [7:0]           lit8;
  logic [PC_W-1:0]      lit11;
  logic [7:0]           awAddr_r;
  logic                 awHave_r;
  logic [31:0]          wData_r;
  logic [3:0]           wStrb_r;
  logic                 wHave_r;

  // ********************************************************
  // instruction cycle sequencer
  // ********************************************************

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_r <= mie_pkg::PH_Q1;
    else
    begin
      case (phase_r)
        mie_pkg::PH_Q1: phase_r <= mie_pkg::PH_Q2;
        mie_pkg::PH_Q2: phase_r <= mie_pkg::PH_Q3;
        mie_pkg::PH_Q3: phase_r <= mie_pkg::PH_Q4;
        mie_pkg::PH_Q4: phase_r <= mie_pkg::PH_Q1;
        default:        phase_r <= mie_pkg::PH_Q1;
      endcase
    end
  end

  // fetch at end of Q1; flushed or halted cycles run a no-op
  // second cycle executes as no-op
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir_r     <= `MIE_NOP_WORD;
      holdPc_r <= 1'b1;
      inject_r <= 1'b1;
    end
    else if (phase_r == mie_pkg::PH_Q1)
    begin
      ir_r     <= (flush_r || !run_r) ? `MIE_NOP_WORD : progData;
      holdPc_r <= (flush_r && flushHold_r) || (!flush_r && !run_r);
      inject_r <= flush_r || !run_r;
    end
  end

  // ********************************************************
  // decode
  // ********************************************************

  // split word into category, opcode and operands
  always_comb
  begin
    op = mie_pkg::OP_NOP;
    case (ir_r[`MIE_CAT_HI:`MIE_CAT_LO])
      2'b00:
      begin
        if (ir_r[11:8] == 4'b0111)
          op = mie_pkg::OP_ADDREG;
        else if (ir_r[11:7] == 5'b00011)
          op = mie_pkg::OP_CLRREG;
        else
          op = mie_pkg::OP_NOP;
      end
      2'b01:
      begin
        case (ir_r[`MIE_BOP_HI:`MIE_BOP_LO])
          2'b00:   op = mie_pkg::OP_BITCLR;
          2'b01:   op = mie_pkg::OP_BITSET;
          2'b10:   op = mie_pkg::OP_SKIPCLR;
          default: op = mie_pkg::OP_SKIPSET;
        endcase
      end
      2'b10:
        op = ir_r[`MIE_GOTO_BIT] ? mie_pkg::OP_JUMP : mie_pkg::OP_NOP;
      default:
      begin
        if (ir_r[11:9] == 3'b111)
          op = mie_pkg::OP_ADDLIT;
        else if (ir_r[11:10] == 2'b00)
          op = mie_pkg::OP_MOVLIT;
        else
          op = mie_pkg::OP_NOP;
      end
    endcase
  end

  // operand fields
  // 8-bit and 11-bit literals
  assign lit8  = ir_r[`MIE_K8_HI:0];
  assign lit11 = PC_W'(ir_r[`MIE_K11_HI:0]);
  assign bitMask = 8'h01 << ir_r[`MIE_BSEL_HI:`MIE_BSEL_LO];
  assign destFile = ir_r[`MIE_DEST_BIT];

  assign usesFile = (op == mie_pkg::OP_ADDREG)
                 || (op == mie_pkg::OP_CLRREG)
                 || (op == mie_pkg::OP_BITCLR)
                 || (op == mie_pkg::OP_BITSET)
                 || (op == mie_pkg::OP_SKIPCLR)
                 || (op == mie_pkg::OP_SKIPSET);

  // ********************************************************
  // data file access
  // ********************************************************

  assign fileAddr = ir_r[`MIE_FADDR_HI:0];
  assign fileRdEn = (phase_r == mie_pkg::PH_Q2) && usesFile;
  // clear of port A still reads it
  assign portARead = fileRdEn && (fileAddr == `MIE_PORT_A_DATA_REG_ADDR);
  assign fileWrEn  = (phase_r == mie_pkg::PH_Q4) && resToFile_r;
  assign fileWrData = res_r;
  assign progAddr   = pc_r;

  // capture the read value at end of Q2
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_r <= 8'h00;
    else if (fileRdEn)
      rd_r <= fileRdData;
  end

  // adder second operand: literal or file value
  assign addB = (op == mie_pkg::OP_ADDLIT) ? lit8 : rd_r;

  mie_alu uAlu
  (
    .opA        (w_r),
    .opB        (addB),
    .sum        (aluSum),
    .carry      (aluC),
    .digitCarry (aluDc),
    .zero       (aluZ)
  );

  // ********************************************************
  // modify in Q3
  // ********************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_r       <= 8'h00;
      resToFile_r <= 1'b0;
      resToW_r    <= 1'b0;
      setC_r      <= 1'b0;
      setDc_r     <= 1'b0;
      setZ_r      <= 1'b0;
      newC_r      <= 1'b0;
      newDc_r     <= 1'b0;
      newZ_r      <= 1'b0;
      skip_r      <= 1'b0;
    end
    else if (phase_r == mie_pkg::PH_Q3)
    begin
      res_r       <= rd_r;
      resToFile_r <= 1'b0;
      resToW_r    <= 1'b0;
      setC_r      <= 1'b0;
      setDc_r     <= 1'b0;
      setZ_r      <= 1'b0;
      newC_r      <= aluC;
      newDc_r     <= aluDc;
      newZ_r      <= aluZ;
      skip_r      <= 1'b0;
      case (op)
        mie_pkg::OP_ADDREG:
        begin
          res_r       <= aluSum;
          resToFile_r <= destFile;
          resToW_r    <= !destFile;
          setC_r      <= 1'b1;
          setDc_r     <= 1'b1;
          setZ_r      <= 1'b1;
        end
        // clear after read, zero flag set
        mie_pkg::OP_CLRREG:
        begin
          res_r       <= 8'h00;
          resToFile_r <= 1'b1;
          setZ_r      <= 1'b1;
          newZ_r      <= 1'b1;
        end
        mie_pkg::OP_BITCLR:
        begin
          res_r       <= rd_r & ~bitMask;
          resToFile_r <= 1'b1;
        end
        mie_pkg::OP_BITSET:
        begin
          res_r       <= rd_r | bitMask;
          resToFile_r <= 1'b1;
        end
        mie_pkg::OP_SKIPCLR:
          skip_r <= ((rd_r & bitMask) == 8'h00);
        mie_pkg::OP_SKIPSET:
          skip_r <= ((rd_r & bitMask) != 8'h00);
        mie_pkg::OP_ADDLIT:
        begin
          res_r    <= aluSum;
          resToW_r <= 1'b1;
          setC_r   <= 1'b1;
          setDc_r  <= 1'b1;
          setZ_r   <= 1'b1;
        end
        mie_pkg::OP_MOVLIT:
        begin
          res_r    <= lit8;
          resToW_r <= 1'b1;
        end
        default:
          res_r <= rd_r;
      endcase
    end
  end

  // ********************************************************
  // commit in Q4
  // ********************************************************

  // working register
  // result to working register for add and move literal, or for add register when select is 0
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      w_r <= `MIE_W_RST;
    else if ((phase_r == mie_pkg::PH_Q4) && resToW_r)
      w_r <= res_r;
  end

  // status flags
  // flags only for arithmetic and clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_r  <= 1'b0;
      dc_r <= 1'b0;
      z_r  <= 1'b0;
    end
    else if (phase_r == mie_pkg::PH_Q4)
    begin
      if (setC_r)
        c_r <= newC_r;
      if (setDc_r)
        dc_r <= newDc_r;
      if (setZ_r)
        z_r <= newZ_r;
    end
  end

  // program counter and no-op insertion
  // jump or taken skip costs two cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_r        <= `MIE_PC_RST;
      flush_r     <= 1'b0;
      flushHold_r <= 1'b0;
    end
    else if (phase_r == mie_pkg::PH_Q4)
    begin
      flush_r     <= skip_r || (op == mie_pkg::OP_JUMP);
      flushHold_r <= (op == mie_pkg::OP_JUMP);
      if (op == mie_pkg::OP_JUMP)
        pc_r <= lit11;
      else if (!holdPc_r)
        pc_r <= pc_r + PC_W'(1);
    end
  end

  // ********************************************************
  // axi4-lite slave
  // ********************************************************
  assign awready = !awHave_r && !bvalid;
  assign wready  = !wHave_r && !bvalid;
  assign arready = !rvalid;

  // hold address and data until both are in
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHave_r  <= 1'b0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end
    else if (awHave_r && wHave_r)
    begin
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHave_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHave_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
    end
  end

  // register write and response
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_r  <= `MIE_CTRL_RST;
      bvalid <= 1'b0;
      bresp  <= `MIE_RESP_OKAY;
    end
    else if (awHave_r && wHave_r)
    begin
      bvalid <= 1'b1;
      bresp  <= `MIE_RESP_OKAY;
      if (awAddr_r[7:2] == `MIE_OFS_CTRL >> 2)
      begin
        if (wStrb_r[0])
          run_r <= wData_r[0];
      end
      else if (awAddr_r[7:2] != `MIE_OFS_STAT >> 2
            && awAddr_r[7:2] != `MIE_OFS_PC >> 2)
        bresp <= `MIE_RESP_SLVERR;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  // register read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `MIE_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= `MIE_RESP_OKAY;
      rdata  <= 32'h0000_0000;
      case (araddr[7:2])
        `MIE_OFS_CTRL >> 2:
          rdata[0] <= run_r;
        `MIE_OFS_STAT >> 2:
        begin
          rdata[7:0]            <= w_r;
          rdata[`MIE_STAT_C]    <= c_r;
          rdata[`MIE_STAT_DC]   <= dc_r;
          rdata[`MIE_STAT_Z]    <= z_r;
          rdata[`MIE_STAT_INJ]  <= inject_r;
          rdata[`MIE_STAT_RUN]  <= run_r;
        end
        `MIE_OFS_PC >> 2:
          rdata[PC_W-1:0] <= pc_r;
        default:
          rresp <= `MIE_RESP_SLVERR;
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

endmodule

// ===== tb/mie_core_asserts.sv
// checker for the execute core, watching its ports only
// assumes a bind onto mie_core and a single clock domain
`timescale 1ns/100ps
`include "mie_cfg.svh"
module mie_core_asserts
#(
  parameter int PC_W = 11
)
(
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // fetch and data file side
  input wire logic [PC_W-1:0]      progAddr,
  input wire logic [`MIE_IW_W-1:0] progData,
  input wire logic [6:0]           fileAddr,
  input wire logic                 fileRdEn,
  input wire logic [7:0]           fileRdData,
  input wire logic                 fileWrEn,
  input wire logic [7:0]           fileWrData,
  input wire logic                 portARead
);
  // *****
  // cycle and read-modify-write checks
  // *****
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  rmw_order_a:
    assert property (fileWrEn |-> $past(fileRdEn, 2)
      && $past(fileAddr, 2) == fileAddr)
    else $error("write without earlier read");
  clr_data_a:
    assert property (fileWrEn && $past(progData[13:7], 3) == 7'b0000011
      |-> fileWrData == 8'h00)
    else $error("clear wrote nonzero");
  port_a_data_reg_read_a:
    assert property (fileRdEn && fileAddr == 7'h05
      |-> portARead ##1 !portARead)
    else $error("port read flag wrong");
  rd_once_a:
    assert property (fileRdEn |=> !fileRdEn [*3])
    else $error("two reads in one cycle");
  pc_hold_a:
    assert property ($changed(progAddr) |=> $stable(progAddr) [*3])
    else $error("pc moved within a cycle");
  faddr_a:
    assert property (fileRdEn |-> fileAddr == $past(progData[6:0]))
    else $error("wrong file address");
  dest_sel_a:
    assert property (fileRdEn && $past(progData[13:8]) == 6'b000111
      |-> ##2 fileWrEn == $past(progData[7], 3))
    else $error("wrong destination");
  bit_clr_a:
    assert property (fileWrEn && $past(progData[13:10], 3) == 4'b0100
      |-> fileWrData == ($past(fileRdData, 2)
      & ~(8'h01 << $past(progData[9:7], 3))))
    else $error("bit clear result wrong");
  bit_set_a:
    assert property (fileWrEn && $past(progData[13:10], 3) == 4'b0101
      |-> fileWrData == ($past(fileRdData, 2)
      | (8'h01 << $past(progData[9:7], 3))))
    else $error("bit set result wrong");
endmodule

bind mie_core mie_core_asserts #(.PC_W(PC_W)) chk
(
  .clk, .rst_n, .progAddr, .progData, .fileAddr, .fileRdEn,
  .fileRdData, .fileWrEn, .fileWrData, .portARead
);

// ===== tb/mie_mem_model.sv
// program memory and data file beside the execute core
// assumes one clock; read data is used inside the read cycle
`timescale 1ns/100ps
module mie_mem_model
(
  // clock
  input wire logic        clk,
  // program memory
  input wire logic [10:0] progAddr,
  output logic [13:0]     progData,
  // data file
  input wire logic [6:0]  fileAddr,
  input wire logic        fileRdEn,
  output logic [7:0]      fileRdData,
  input wire logic        fileWrEn,
  input wire logic [7:0]  fileWrData,
  input wire logic        portARead
);
  logic [13:0] prog [0:2047];
  logic [7:0]  file [0:127];
  logic        pendChange;

  // unused words read as no-ops
  initial
    foreach (prog[i])
      prog[i] = 14'h0000;
  // word at the current address
  assign progData = prog[progAddr];
  // value only while strobed, inverse otherwise
  assign fileRdData = fileRdEn ? file[fileAddr] : ~file[fileAddr];
  // store on the write strobe
  always @(posedge clk)
    if (fileWrEn)
      file[fileAddr] <= fileWrData;
  always @(posedge clk)
    if (portARead)
      pendChange <= 1'b0;
endmodule

// ===== tb/mcu_instruction_execute_tb.sv
// self-checking bench for the execute core
// assumes mie_core, its checker bind and the memory model
`timescale 1ns/100ps
module mcu_instruction_execute_tb;
  // *****
  // signals
  // *****
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [10:0] progAddr;
  logic [13:0] progData;
  logic [6:0]  fileAddr;
  logic [7:0]  fileRdData, fileWrData, rnd;
  logic        fileRdEn, fileWrEn, portARead;
  logic [33:0] expQ [$];
  logic [31:0] mskQ [$];
  logic [1:0]  bQ [$];
  logic [14:0] fQ [$];
  logic [7:0]  v [8];
  logic [13:0] prog [10];
  logic [10:0] w1, s20, w2;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  mie_core uut
  (
    .clk, .rst_n, .progAddr, .progData, .fileAddr, .fileRdEn,
    .fileRdData, .fileWrEn, .fileWrData, .portARead, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready
  );
  mie_mem_model mem
  (
    .clk, .progAddr, .progData, .fileAddr, .fileRdEn, .fileRdData,
    .fileWrEn, .fileWrData, .portARead
  );

  // *****
  // helpers
  // *****
  function automatic logic [10:0] add8(input logic [7:0] a, b);
    logic [8:0] s;
    logic [4:0] h;
    s = a + b;
    h = a[3:0] + b[3:0];
    return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  task automatic chk(input string what, input logic [33:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // bus write, response noted for the monitor
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rs);
    logic aOk, dOk;
    aOk = 1'b0;
    dOk = 1'b0;
    bQ.push_back(rs);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aOk && dOk))
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      aOk = aOk | awready;
      dOk = dOk | wready;
    end
    while (!bvalid)
      @(posedge clk);
    bready <= 1'b0;
  endtask

  // bus read, masked expectation noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [1:0] rs,
                    input logic [31:0] e, m);
    expQ.push_back({rs, e & m});
    mskQ.push_back(m);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge clk);
    while (!arready);
    arvalid <= 1'b0;
    while (!rvalid)
      @(posedge clk);
    rready <= 1'b0;
  endtask

  // compare each result with the oldest note
  always @(posedge clk)
  begin
    if (rvalid && rready)
      chk("read", expQ.pop_front(), {rresp, rdata & mskQ.pop_front()});
    if (bvalid && bready)
      chk("bresp", bQ.pop_front(), bresp);
    if (fileWrEn)
      chk("filewr", fQ.pop_front(), {fileAddr, fileWrData});
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // *****
  // main sequence: two random rounds
  // *****
  initial
  begin
    rnd = 8'h5A;
    for (int r = 0; r < 2; r++)
    begin
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 2'h0, 32'h0000_0000, 32'h0000_0001);
      rd(8'h08, 2'h0, 32'h0000_0000, 32'h0000_07FF);
      rd(8'h0C, 2'h2, 32'h0000_0000, 32'hFFFF_FFFF);
      wr(8'h0C, 32'h0000_0001, 2'h2);
      foreach (v[i])
      begin
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        v[i] = rnd;
      end
      prog = '{14'h0185, {6'h30, v[0]}, {6'h3E, v[1]}, 14'h07A0,
               14'h0721, {4'h4, v[7][2:0], 7'h22},
               {4'h5, v[7][5:3], 7'h7F}, {4'h7, v[7][5:3], 7'h7F},
               14'h3E01, 14'h2809};
      foreach (prog[i])
        mem.prog[i] = prog[i];
      mem.file[7'h05] = v[6];
      mem.file[7'h20] = v[2];
      mem.file[7'h21] = v[3];
      mem.file[7'h22] = v[4];
      mem.file[7'h7F] = v[5];
      mem.pendChange = 1'b1;
      w1 = add8(v[0], v[1]);
      s20 = add8(w1[7:0], v[2]);
      w2 = add8(w1[7:0], v[3]);
      fQ.push_back({7'h05, 8'h00});
      fQ.push_back({7'h20, s20[7:0]});
      fQ.push_back({7'h22, v[4] & ~(8'h01 << v[7][2:0])});
      fQ.push_back({7'h7F, v[5] | (8'h01 << v[7][5:3])});
      wr(8'h00, 32'h0000_0001, 2'h0);
      // eleven instruction cycles of four clocks fit well inside
      repeat (60) @(posedge clk);
      wr(8'h00, 32'h0000_0000, 2'h0);
      rd(8'h04, 2'h0, {21'h0, w2}, 32'h0000_17FF);
      rd(8'h08, 2'h0, 32'h0000_0009, 32'h0000_07FF);
      chk("pend", 34'h0, {33'h0, mem.pendChange});
      $display("round %0d done", r);
    end
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule
